// ### cfb_defines.svh
/*
  Constants for the CAN filter and buffer-status block.
  Assumes inclusion by its bare name from the package and design file.
*/
`ifndef CFB_DEFINES_SVH
`define CFB_DEFINES_SVH
`define CFB_ADDR_W 8
`define CFB_DATA_W 16
`define CFB_NFILT 16
`define CFB_NBUF 32
`define CFB_OFS_FSID 8'h00
`define CFB_OFS_FEID 8'h10
`define CFB_OFS_FUL_LO 8'h20
`define CFB_OFS_FUL_HI 8'h21
`define CFB_OFS_CTRL 8'h22
`define CFB_OFS_ISTAT 8'h23
`define CFB_OFS_IEN 8'h24
`define CFB_OFS_ICLR 8'h25
`define CFB_OFS_BSID 8'h40
`define CFB_OFS_BEID 8'h80
`define CFB_OFS_END 8'hA0
`define CFB_FSID_MASK 16'hFFEB
`define CFB_FSID_XBIT 3
`define CFB_BSID_MASK 16'h1FFF
`define CFB_BEID_MASK 16'h0FFF
`define CFB_ZERO16 16'h0000
`define CFB_HALF 16
`endif

// ### cfb_pkg.sv
/*
  Types for the CAN filter and buffer-status block.
  Assumes cfb_defines.svh is on the include path.
*/
`include "cfb_defines.svh"
package cfb_pkg;
  typedef struct packed {
    logic [28:0] ident;
    logic ext;
    logic [4:0] buf_idx;
  } cfb_frame_t;
  typedef struct packed {
    logic [`CFB_ADDR_W-1:0] addr;
    logic [`CFB_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cfb_bus_t;
  typedef enum logic [1:0] {CFB_IDLE, CFB_MATCH, CFB_STORE} cfb_state_t;
endpackage

// ### cfb_top.sv
/*
  Acceptance filtering and receive-buffer occupancy for a CAN controller.
  Assumes received frames arrive as one-cycle strobes and a register master
  that reads data one cycle after the read strobe.
*/
`timescale 1ns/1ns
`include "cfb_defines.svh"
// Function
// - Pass only when all enabled identifier bits match
// - Type control: extended-match bit selects frame type
// - Stored message sets its buffer's full flag
// - Software write only clears full flags
// - Buffers 16-31 in second register, reset zero
// - Buffer extended word holds identifier bits 17-6
// - Buffer extended word top four bits read zero
// - Filter extended low holds bits 15-0
module cfb_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire cfb_pkg::cfb_bus_t bus_i,
  input wire cfb_pkg::cfb_frame_t frame_i,
  input wire logic frame_vld_i,
  output logic [`CFB_DATA_W-1:0] rdata_o,
  output logic accept_o,
  output logic [3:0] hit_idx_o,
  output logic irq_o
);
  import cfb_pkg::*;

  logic [15:0] fsid_ff [`CFB_NFILT];
  logic [15:0] feid_ff [`CFB_NFILT];
  logic [15:0] bsid_ff [`CFB_NBUF];
  logic [15:0] beid_ff [`CFB_NBUF];
  logic [`CFB_NBUF-1:0] full_ff, nxt_full;
  logic type_ctl_ff, nxt_type_ctl;
  logic [1:0] ist_ff, nxt_ist, ien_ff, nxt_ien;
  logic [15:0] rdata_ff, nxt_rdata;
  logic accept_ff, nxt_accept, irq_ff, nxt_irq;
  logic [3:0] hit_ff, nxt_hit;
  logic hit;
  logic [3:0] hit_idx;
  logic [7:0] a;

  assign a = bus_i.addr;

  // Exact match only: this block has no mask register
  function automatic logic filt_match(input logic [15:0] s,
                                      input logic [15:0] e,
                                      input logic tc,
                                      input cfb_frame_t f);
    logic ok;
    ok = 1'b1;
    if (f.ext) begin
      if (f.ident[28:18] != s[15:5]) ok = 1'b0;
      if (f.ident[17:16] != s[1:0]) ok = 1'b0;
      if (f.ident[15:0] != e) ok = 1'b0;
    end else begin
      if (f.ident[10:0] != s[15:5]) ok = 1'b0;
    end
    if (tc && (s[`CFB_FSID_XBIT] != f.ext)) ok = 1'b0;
    return ok;
  endfunction

  // Descending scan so the lowest matching filter is the one reported
  always_comb begin
    hit = 1'b0;
    hit_idx = 4'h0;
    for (int i = `CFB_NFILT - 1; i >= 0; i--) begin
      if (filt_match(fsid_ff[i], feid_ff[i], type_ctl_ff, frame_i)) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
  end

  always_comb begin
    nxt_full = full_ff;
    nxt_type_ctl = type_ctl_ff;
    nxt_ien = ien_ff;
    nxt_ist = ist_ff;
    nxt_accept = 1'b0;
    nxt_hit = hit_ff;
    if (bus_i.wr) begin
      case (a)
        `CFB_OFS_FUL_LO: nxt_full[15:0] = full_ff[15:0] & bus_i.wdata;
        `CFB_OFS_FUL_HI: nxt_full[31:16] = full_ff[31:16] & bus_i.wdata;
        `CFB_OFS_CTRL: nxt_type_ctl = bus_i.wdata[0];
        `CFB_OFS_IEN: nxt_ien = bus_i.wdata[1:0];
        `CFB_OFS_ICLR: nxt_ist = ist_ff & ~bus_i.wdata[1:0];
        default: ;
      endcase
    end
    // Set after clear so a same-cycle store is never lost
    if (frame_vld_i) begin
      if (hit) begin
        nxt_full[frame_i.buf_idx] = 1'b1;
        nxt_accept = 1'b1;
        nxt_hit = hit_idx;
        nxt_ist[0] = 1'b1;
        if (full_ff[frame_i.buf_idx]) nxt_ist[1] = 1'b1;
      end
    end
    nxt_irq = |(nxt_ist & nxt_ien);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      full_ff <= '0;
      type_ctl_ff <= 1'b0;
      ist_ff <= 2'h0;
      ien_ff <= 2'h0;
      accept_ff <= 1'b0;
      hit_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      full_ff <= nxt_full;
      type_ctl_ff <= nxt_type_ctl;
      ist_ff <= nxt_ist;
      ien_ff <= nxt_ien;
      accept_ff <= nxt_accept;
      hit_ff <= nxt_hit;
      irq_ff <= nxt_irq;
    end
  end

  // Identifier arrays have no reset: contents are undefined until written
  always_ff @(posedge clock_i) begin
    if (bus_i.wr) begin
      for (int i = 0; i < `CFB_NFILT; i++) begin
        if (a == `CFB_OFS_FSID + 8'(i))
          fsid_ff[i] <= bus_i.wdata & `CFB_FSID_MASK;
        if (a == `CFB_OFS_FEID + 8'(i))
          feid_ff[i] <= bus_i.wdata;
      end
      for (int i = 0; i < `CFB_NBUF; i++) begin
        if (a == `CFB_OFS_BSID + 8'(i))
          bsid_ff[i] <= bus_i.wdata & `CFB_BSID_MASK;
        if (a == `CFB_OFS_BEID + 8'(i))
          beid_ff[i] <= bus_i.wdata & `CFB_BEID_MASK;
      end
    end
    if (frame_vld_i && hit) begin
      bsid_ff[frame_i.buf_idx] <= {3'h0, (frame_i.ext ?
        frame_i.ident[28:18] : frame_i.ident[10:0]), 1'b0,
        frame_i.ext};
      beid_ff[frame_i.buf_idx] <= {4'h0, frame_i.ident[17:6]};
    end
  end

  always_comb begin
    nxt_rdata = `CFB_ZERO16;
    if (bus_i.rd) begin
      // Unmapped and write-only offsets fall through and read as zero, except 8'h60-8'h7F, which repeat bsid_ff
      if (a < `CFB_OFS_FEID)
        nxt_rdata = fsid_ff[a[3:0]];
      else if (a >= `CFB_OFS_FEID && a < `CFB_OFS_FUL_LO)
        nxt_rdata = feid_ff[a[3:0]];
      else if (a == `CFB_OFS_FUL_LO)
        nxt_rdata = full_ff[15:0];
      else if (a == `CFB_OFS_FUL_HI)
        nxt_rdata = full_ff[31:16];
      else if (a == `CFB_OFS_CTRL)
        nxt_rdata = {15'h0000, type_ctl_ff};
      else if (a == `CFB_OFS_ISTAT)
        nxt_rdata = {14'h0000, ist_ff};
      else if (a == `CFB_OFS_IEN)
        nxt_rdata = {14'h0000, ien_ff};
      else if (a >= `CFB_OFS_BSID && a < `CFB_OFS_BEID)
        nxt_rdata = bsid_ff[a[4:0]];
      else if (a >= `CFB_OFS_BEID && a < `CFB_OFS_END)
        nxt_rdata = beid_ff[a[4:0]] & `CFB_BEID_MASK;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) rdata_ff <= `CFB_ZERO16;
    else rdata_ff <= nxt_rdata;
  end

  assign rdata_o = rdata_ff;
  assign accept_o = accept_ff;
  assign hit_idx_o = hit_ff;
  assign irq_o = irq_ff;

  property p_set_full;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit) |=> full_ff[$past(frame_i.buf_idx)];
  endproperty
  a_set_full: assert property (p_set_full) else $error("full not set");

  property p_clear_only;
    @(posedge clock_i) disable iff (!rst_b_i)
    !(frame_vld_i && hit) |=> ((full_ff & ~$past(full_ff)) == '0);
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("flag set");

  property p_accept;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept_o |-> $past(frame_vld_i && hit);
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept");

  property p_type;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit && type_ctl_ff) |->
      fsid_ff[hit_idx][`CFB_FSID_XBIT] == frame_i.ext;
  endproperty
  a_type: assert property (p_type) else $error("type mismatch");

  property p_hi_read;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.rd && a == `CFB_OFS_FUL_HI) |=> rdata_o == $past(full_ff[31:16]);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("bad hi read");

  property p_beid_top;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.rd && a >= `CFB_OFS_BEID && a < `CFB_OFS_END) |=>
      rdata_o[15:12] == 4'h0;
  endproperty
  a_beid_top: assert property (p_beid_top) else $error("top bits");

  property p_beid_val;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit) |=>
      beid_ff[$past(frame_i.buf_idx)][11:0] == $past(frame_i.ident[17:6]);
  endproperty
  a_beid_val: assert property (p_beid_val) else $error("ext word");

  property p_bsid_ide;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit) |=>
      bsid_ff[$past(frame_i.buf_idx)][0] == $past(frame_i.ext);
  endproperty
  a_bsid_ide: assert property (p_bsid_ide) else $error("ide bit");

  property p_feid;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.wr && a == `CFB_OFS_FEID) |=> feid_ff[0] == $past(bus_i.wdata);
  endproperty
  a_feid: assert property (p_feid) else $error("feid write");

  // Stored-state checks on the flops, several of them against past frame_i or bus_i inputs driven by the bench
  property p_match_std;
    @(posedge clock_i) disable iff (!rst_b_i)
    (accept_o && !$past(frame_i.ext)) |->
      $past(fsid_ff[hit_idx][15:5]) == $past(frame_i.ident[10:0]);
  endproperty
  a_match_std: assert property (p_match_std) else $error("no match");

  property p_match_ext;
    @(posedge clock_i) disable iff (!rst_b_i)
    (accept_o && $past(frame_i.ext)) |->
      $past({fsid_ff[hit_idx][15:5], fsid_ff[hit_idx][1:0],
      feid_ff[hit_idx]}) == $past(frame_i.ident);
  endproperty
  a_match_ext: assert property (p_match_ext) else $error("no match");

  property p_hit_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
    $changed(hit_idx_o) |-> accept_o;
  endproperty
  a_hit_hold: assert property (p_hit_hold) else $error("hit moved");

  property p_sw_clear;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.wr && a == `CFB_OFS_FUL_LO && !frame_vld_i) |=>
      full_ff[15:0] == $past(full_ff[15:0] & bus_i.wdata);
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("sw set");

  property p_full_rst;
    @(posedge clock_i) !rst_b_i |=> (full_ff == '0);
  endproperty
  a_full_rst: assert property (p_full_rst) else $error("not reset");

  property p_lo_read;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.rd && a == `CFB_OFS_FUL_LO) |=> rdata_o == $past(full_ff[15:0]);
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("bad lo read");

  property p_stat_set;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit) |=> ist_ff[0];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("no event");

  property p_irq;
    @(posedge clock_i) disable iff (!rst_b_i)
    irq_o == |(ist_ff & ien_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");

  property p_bsid_sid;
    @(posedge clock_i) disable iff (!rst_b_i)
    (frame_vld_i && hit) |=> bsid_ff[$past(frame_i.buf_idx)][12:2] ==
      $past(frame_i.ext ? frame_i.ident[28:18] : frame_i.ident[10:0]);
  endproperty
  a_bsid_sid: assert property (p_bsid_sid) else $error("std word");

  property p_beid_wr;
    @(posedge clock_i) disable iff (!rst_b_i)
    (bus_i.wr && a == `CFB_OFS_BEID) |=> beid_ff[0][15:12] == 4'h0;
  endproperty
  a_beid_wr: assert property (p_beid_wr) else $error("top bits set");
endmodule

// ### cfb_node.sv
/*
  CAN node model that hands received frames to the filter block.
  Assumes frames are one-cycle strobes taken on a rising clock edge.
*/
`timescale 1ns/1ns
module cfb_node (
  input wire logic clock_i,
  output cfb_pkg::cfb_frame_t frame_o,
  output logic vld_o
);
  import cfb_pkg::*;
  initial begin
    frame_o = '0;
    vld_o = 1'b0;
  end
  task automatic send(input cfb_frame_t f);
    @(posedge clock_i);
    frame_o <= f;
    vld_o <= 1'b1;
    @(posedge clock_i);
    vld_o <= 1'b0;
    // Released lines change so a stale frame is never reused
    frame_o <= ~f;
  endtask
endmodule

// ### tb_top.sv
/*
  Self-checking bench for the filter and buffer-status block.
  Assumes the design files and cfb_node.sv are compiled first.
*/
`timescale 1ns/1ns
`include "cfb_defines.svh"
module tb_top;
  import cfb_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  cfb_bus_t bus = '0;
  cfb_frame_t frame;
  logic vld, acc, irq;
  logic [15:0] rdata;
  logic [3:0] hit;
  int miscompares = 0;
  int check_count = 0;
  logic [28:0] ids [16];
  logic [28:0] id;
  logic [31:0] full = '0;
  logic [31:0] r;
  logic [1:0] st = '0;
  logic [1:0] en = '0;
  int f, b;
  cfb_top DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus),
    .frame_i(frame), .frame_vld_i(vld), .rdata_o(rdata),
    .accept_o(acc), .hit_idx_o(hit), .irq_o(irq));
  cfb_node node (.clock_i(clock_i), .frame_o(frame), .vld_o(vld));
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    @(negedge clock_i);
    check(rdata, e);
  endtask
  function automatic logic [15:0] fstd(input logic [28:0] i, input logic x);
    return {i[28:18], 1'b0, x, 1'b0, i[17:16]};
  endfunction
  task automatic rx(input logic [28:0] i, input logic x, input int bi,
                    input logic a, input int h);
    node.send({i, x, bi[4:0]});
    @(negedge clock_i);
    check({15'h0, acc}, {15'h0, a});
    if (a) begin
      check({12'h0, hit}, h[15:0]);
      if (full[bi]) st[1] = 1'b1;
      full[bi] = 1'b1;
      st[0] = 1'b1;
    end
    check({15'h0, irq}, {15'h0, |(st & en)});
  endtask
  initial begin
    void'($urandom(98));
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(`CFB_OFS_FUL_LO, 16'h0000);
    rd(`CFB_OFS_FUL_HI, 16'h0000);
    rd(8'h30, 16'h0000);
    wr(`CFB_OFS_BEID, 16'hFFFF);
    rd(`CFB_OFS_BEID, 16'h0FFF);
    wr(`CFB_OFS_BSID, 16'hFFFF);
    rd(`CFB_OFS_BSID, 16'h1FFF);
    $display("reset test done");
    // Filter 15 is the only standard-frame filter
    for (f = 0; f < 16; f++) begin
      r = $urandom;
      ids[f] = r[28:0];
      if (f == 15) ids[f][17:0] = '0;
      wr(`CFB_OFS_FSID + f[7:0], fstd(ids[f], f != 15));
      wr(`CFB_OFS_FEID + f[7:0], ids[f][15:0]);
      rd(`CFB_OFS_FEID + f[7:0], ids[f][15:0]);
      rd(`CFB_OFS_FSID + f[7:0], fstd(ids[f], f != 15));
    end
    wr(`CFB_OFS_CTRL, 16'h0001);
    wr(`CFB_OFS_IEN, 16'h0003);
    en = 2'b11;
    for (b = 0; b < 32; b++) begin
      f = $urandom_range(14);
      rx(ids[f], 1'b1, b, 1'b1, f);
      rd(`CFB_OFS_BEID + b[7:0], {4'h0, ids[f][17:6]});
      rd(`CFB_OFS_BSID + b[7:0], {3'h0, ids[f][28:18], 2'b01});
      rd(`CFB_OFS_FUL_LO, full[15:0]);
      rd(`CFB_OFS_FUL_HI, full[31:16]);
    end
    $display("store test done");
    id = {18'h0, ids[0][28:18]};
    rx(id, 1'b0, 3, 1'b0, 0);
    rx(ids[15], 1'b1, 4, 1'b0, 0);
    rx({18'h0, ids[15][28:18]}, 1'b0, 3, 1'b1, 15);
    wr(`CFB_OFS_CTRL, 16'h0000);
    rx(id, 1'b0, 5, 1'b1, 0);
    for (b = 0; b < 8; b++) begin
      f = $urandom_range(14);
      rx(ids[f] ^ (29'h1 << $urandom_range(28)), 1'b1, b, 1'b0, 0);
    end
    $display("filter test done");
    r = $urandom;
    wr(`CFB_OFS_FUL_LO, r[15:0]);
    full[15:0] &= r[15:0];
    wr(`CFB_OFS_FUL_HI, r[31:16]);
    full[31:16] &= r[31:16];
    wr(`CFB_OFS_FUL_LO, 16'hFFFF);
    wr(`CFB_OFS_FUL_HI, 16'hFFFF);
    rd(`CFB_OFS_FUL_LO, full[15:0]);
    rd(`CFB_OFS_FUL_HI, full[31:16]);
    wr(`CFB_OFS_IEN, 16'h0000);
    en = 2'b00;
    rd(`CFB_OFS_ISTAT, {14'h0, st});
    check({15'h0, irq}, 16'h0000);
    wr(`CFB_OFS_ICLR, 16'h0001);
    st[0] = 1'b0;
    wr(`CFB_OFS_IEN, 16'h0003);
    en = 2'b11;
    rd(`CFB_OFS_ISTAT, {14'h0, st});
    check({15'h0, irq}, {15'h0, |st});
    wr(`CFB_OFS_ICLR, 16'h0002);
    st = 2'b00;
    rd(`CFB_OFS_ISTAT, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    $display("clear test done");
    final_report();
  end
  // Whole run needs about 540 cycles
  initial begin
    #(100 * 20000);
    miscompares++;
    final_report();
  end
endmodule
